// File: logic/bcet_pkg.sv
/*
  Shared constants and types for the instruction timing sequencer.
  Assumes: one system clock; all users name items as bcet_pkg::name.
*/
package bcet_pkg;
  localparam int ADDR_W = 16;
  localparam int CNT_W = 32;
  localparam int INSTR_COUNT = 109;
  localparam int CORE_MAX_HZ = 25_000_000;
  localparam logic [3:0] MAX_CYCLES = 4'h8;
  // entry layout: [6] conditional, [5:4] bytes, [3:0] cycles not taken
  localparam int COND_BIT = 6;
  localparam int BYTES_MSB = 5;
  localparam int BYTES_LSB = 4;
  localparam int CYC_MSB = 3;
  typedef logic [7:0] bcet_entry_type;
  typedef bcet_entry_type bcet_col_type [0:15];
  // columns by low opcode bits, rows by high nibble
  localparam bcet_col_type TBL_BRANCH = '{8'h11, 8'h73, 8'h73, 8'h73,
    8'h62, 8'h62, 8'h62, 8'h62, 8'h23, 8'h33, 8'h22, 8'h22, 8'h22,
    8'h22, 8'h13, 8'h13};
  localparam bcet_entry_type ENTRY_ABS = 8'h23;
  localparam bcet_col_type TBL_MISC = '{8'h34, 8'h34, 8'h15, 8'h15,
    8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22,
    8'h22, 8'h13, 8'h13};
  localparam bcet_col_type TBL_ACC = '{8'h11, 8'h11, 8'h11, 8'h11,
    8'h33, 8'h33, 8'h33, 8'h13, 8'h13, 8'h13, 8'h11, 8'h11, 8'h11,
    8'h11, 8'h13, 8'h13};
  localparam bcet_col_type TBL_IMM = '{8'h11, 8'h11, 8'h22, 8'h22,
    8'h22, 8'h22, 8'h22, 8'h22, 8'h18, 8'h22, 8'h14, 8'h73, 8'h11,
    8'h11, 8'h11, 8'h11};
  localparam bcet_col_type TBL_DIRECT = '{8'h22, 8'h22, 8'h22, 8'h22,
    8'h22, 8'h22, 8'h22, 8'h33, 8'h33, 8'h22, 8'h11, 8'h74, 8'h22,
    8'h73, 8'h22, 8'h22};
  localparam bcet_col_type TBL_IND = '{8'h12, 8'h12, 8'h12, 8'h12,
    8'h12, 8'h12, 8'h12, 8'h22, 8'h22, 8'h12, 8'h22, 8'h74, 8'h12,
    8'h12, 8'h12, 8'h12};
  localparam bcet_col_type TBL_BANK = '{8'h11, 8'h11, 8'h11, 8'h11,
    8'h11, 8'h11, 8'h11, 8'h22, 8'h22, 8'h11, 8'h22, 8'h73, 8'h11,
    8'h62, 8'h11, 8'h11};
  localparam logic [2:0] COL_BRANCH = 3'h0;
  localparam logic [2:0] COL_ABS = 3'h1;
  localparam logic [2:0] COL_MISC = 3'h2;
  localparam logic [2:0] COL_ACC = 3'h3;
  localparam logic [2:0] COL_IMM = 3'h4;
  localparam logic [2:0] COL_DIRECT = 3'h5;
  localparam logic [7:0] OP_JUMP_IF_ACC_ZERO = 8'h60;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_UNDEFINED = 8'ha5;
  typedef enum {ST_OPCODE, ST_BUSY} bcet_state_type;
  typedef enum {DBG_RUN, DBG_HALT, DBG_STEP} bcet_dbg_state_type;
endpackage

// File: logic/bcet_dbg_if.sv
/*
  Carrier between the sequencer and its debug controller.
  Assumes: both ends on the same clock.
*/
`timescale 1ns/10ps
interface bcet_dbg_if;
  logic [bcet_pkg::ADDR_W-1:0] pc;
  logic boundary;
  logic retire;
  logic hold;
  logic halted;
  modport core (output pc, boundary, retire, input hold, halted);
  modport dbg (input pc, boundary, retire, output hold, halted);
endinterface

// File: logic/bcet_decode.sv
/*
  Opcode to length, base cycle count and branch class lookup.
  Assumes: opcode is stable for the cycle in which it is read.
*/
`timescale 1ns/10ps
module bcet_decode (
  input wire logic [7:0] opcode,   // opcode under decode
  output logic [1:0] bytes,        // instruction length
  output logic [3:0] cycles,       // cycles when not taken
  output logic cond,               // conditional branch
  output logic rel_jump,           // unconditional relative jump
  output logic undefined           // the one unused encoding
);
  bcet_pkg::bcet_entry_type entry;
  logic [3:0] row;

  assign row = opcode[7:4];

  // encoding layout follows the compatible map exactly
  always_comb begin
    entry = bcet_pkg::ENTRY_ABS;
    if (opcode[3]) begin
      entry = bcet_pkg::TBL_BANK[row];
    end else if (opcode[2:1] == bcet_pkg::COL_DIRECT[2:1] + 2'h1) begin
      entry = bcet_pkg::TBL_IND[row];
    end else begin
      case (opcode[2:0])
        bcet_pkg::COL_BRANCH: entry = bcet_pkg::TBL_BRANCH[row];
        bcet_pkg::COL_MISC: entry = bcet_pkg::TBL_MISC[row];
        bcet_pkg::COL_ACC: entry = bcet_pkg::TBL_ACC[row];
        bcet_pkg::COL_IMM: entry = bcet_pkg::TBL_IMM[row];
        bcet_pkg::COL_DIRECT: entry = bcet_pkg::TBL_DIRECT[row];
        default: entry = bcet_pkg::ENTRY_ABS;
      endcase
    end
  end

  assign bytes = entry[bcet_pkg::BYTES_MSB:bcet_pkg::BYTES_LSB];
  assign cycles = entry[bcet_pkg::CYC_MSB:0];
  assign cond = entry[bcet_pkg::COND_BIT];
  assign rel_jump = (opcode == bcet_pkg::OP_SHORT_JUMP);
  assign undefined = (opcode == bcet_pkg::OP_UNDEFINED);
endmodule

// File: logic/bcet_debug.sv
/*
  Debug controller: breakpoint, halt, run and single step.
  Assumes: request inputs are one-cycle pulses on the system clock.
*/
`timescale 1ns/10ps
module bcet_debug (
  input wire logic clk,                            // system clock
  input wire logic reset,                          // async, active high
  input wire logic halt_req,                       // stop request pulse
  input wire logic run_req,                        // resume request pulse
  input wire logic step_req,                       // step request pulse
  input wire logic bp_enable,                      // breakpoint armed
  input wire logic [bcet_pkg::ADDR_W-1:0] bp_addr, // breakpoint address
  bcet_dbg_if.dbg link                             // sequencer side
);
  bcet_pkg::bcet_dbg_state_type state_reg;
  logic skip_reg;
  logic bp_hit;

  // skip stops a resume from re-hitting the breakpoint it sits on
  assign bp_hit = bp_enable && link.boundary && !skip_reg &&
                  (link.pc == bp_addr);

  // hold only bites at a boundary, so no instruction is cut
  assign link.hold = (state_reg == bcet_pkg::DBG_HALT) ||
                     (state_reg == bcet_pkg::DBG_RUN && bp_hit);
  assign link.halted = (state_reg == bcet_pkg::DBG_HALT) && link.boundary;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= bcet_pkg::DBG_RUN;
    end else begin
      case (state_reg)
        bcet_pkg::DBG_RUN: begin
          if (halt_req || bp_hit) begin
            state_reg <= bcet_pkg::DBG_HALT;
          end
        end
        bcet_pkg::DBG_HALT: begin
          if (step_req) begin
            state_reg <= bcet_pkg::DBG_STEP;
          end else if (run_req) begin
            state_reg <= bcet_pkg::DBG_RUN;
          end
        end
        default: begin
          if (link.retire) begin
            state_reg <= bcet_pkg::DBG_HALT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      skip_reg <= 1'b0;
    end else if (state_reg == bcet_pkg::DBG_HALT && (step_req || run_req)) begin
      skip_reg <= 1'b1;
    end else if (link.retire) begin
      skip_reg <= 1'b0;
    end
  end
endmodule

// File: logic/bcet_core.sv
/*
  Instruction timing sequencer: takes program bytes, spends the
  documented cycles on each instruction, resolves relative branches
  and reports each retired instruction.
  Assumes: program memory, branch condition, accumulator-zero and
  absolute jump inputs come from logic on the same clock.
*/
`timescale 1ns/10ps

// Notes on behaviour
// - all timing counted in system clock cycles, no machine cycles.
// - most instructions take as many cycles as they have bytes.
// - a not-taken conditional branch takes one cycle less than taken.
// - at most 8 cycles; divide takes 8, multiply 4, one byte each.
// - runs 0 to 25 MHz; peak one instruction retired per clock.
// - full compatible set of 109 instructions is sequenced.
// - encodings and flag effects match reference; only timing differs.
// - add, add-carry, subtract-borrow: bank 1/1, direct/imm 2/2, ind 1/2.
// - inc/dec acc, bank, data pointer 1 cycle; direct 2/2; ind 1/2.
// - and/or/xor into acc: bank 1 cycle, other sources 2 cycles.
// - logic op into direct byte: from acc 2/2, from immediate 3/3.
// - debug gives breakpoints, run, stop and step.
// - debug uses no core memory, stack or timers; fully non-intrusive.
// - relative offset is signed 8-bit, added to next instruction addr.
// - jump-if-acc-zero is 2 bytes, 2 cycles not taken, 3 taken.
module bcet_core #(
  parameter int ADDR_W = bcet_pkg::ADDR_W,
  parameter int CNT_W = bcet_pkg::CNT_W
) (
  input wire logic clk,                    // system clock
  input wire logic reset,                  // async, active high
  input wire logic fetch_valid,            // program byte present
  input wire logic [7:0] fetch_byte,       // program byte
  output logic fetch_ready,                // byte wanted this cycle
  output logic [ADDR_W-1:0] fetch_addr,    // address of wanted byte
  input wire logic branch_cond,            // condition of current branch
  input wire logic acc_zero,               // accumulator is zero
  input wire logic jump_valid,             // absolute redirect at retire
  input wire logic [ADDR_W-1:0] jump_addr, // absolute redirect target
  input wire logic dbg_halt_req,           // debug stop pulse
  input wire logic dbg_run_req,            // debug resume pulse
  input wire logic dbg_step_req,           // debug single step pulse
  input wire logic dbg_bp_enable,          // breakpoint armed
  input wire logic [ADDR_W-1:0] dbg_bp_addr, // breakpoint address
  output logic dbg_halted,                 // stopped at a boundary
  output logic retire_valid,               // one instruction retired
  output logic [7:0] retire_opcode,        // its opcode
  output logic [ADDR_W-1:0] retire_addr,   // its first byte address
  output logic [1:0] retire_bytes,         // its length
  output logic [3:0] retire_cycles,        // cycles it used
  output logic retire_taken,               // branch was taken
  output logic retire_undefined,           // unused encoding met
  output logic [CNT_W-1:0] cycle_count,    // clocks since reset
  output logic [CNT_W-1:0] instr_count     // instructions retired
);
  bcet_dbg_if dbg_link ();

  bcet_pkg::bcet_state_type state_reg;
  logic [7:0] op_reg;
  logic [3:0] cnt_reg;
  logic [7:0] rel_reg;
  logic take_reg;
  logic [ADDR_W-1:0] pc_reg;
  logic [ADDR_W-1:0] start_reg;
  logic retire_valid_reg;
  logic [7:0] retire_opcode_reg;
  logic [ADDR_W-1:0] retire_addr_reg;
  logic [1:0] retire_bytes_reg;
  logic [3:0] retire_cycles_reg;
  logic retire_taken_reg;
  logic retire_undefined_reg;
  logic [CNT_W-1:0] cycle_count_reg;
  logic [CNT_W-1:0] instr_count_reg;

  logic busy;
  logic [7:0] opcode_cur;
  logic [3:0] cnt_cur;
  logic [ADDR_W-1:0] start_cur;
  logic [1:0] dec_bytes;
  logic [3:0] dec_cycles;
  logic dec_cond;
  logic dec_rel_jump;
  logic dec_undefined;
  logic active;
  logic need_fetch;
  logic advance;
  logic byte_taken;
  logic last_base;
  logic cond_true;
  logic take_now;
  logic retire_now;
  logic [ADDR_W-1:0] rel_target;
  logic [3:0] cnt_next;

  assign busy = (state_reg == bcet_pkg::ST_BUSY);
  // the opcode cycle decodes straight from the fetch bus, which is
  // what lets a one-byte instruction start and retire in one clock
  assign opcode_cur = busy ? op_reg : fetch_byte;
  assign cnt_cur = busy ? cnt_reg : 4'h0;
  assign start_cur = busy ? start_reg : pc_reg;

  bcet_decode u_decode (
    .opcode(opcode_cur),
    .bytes(dec_bytes),
    .cycles(dec_cycles),
    .cond(dec_cond),
    .rel_jump(dec_rel_jump),
    .undefined(dec_undefined)
  );

  bcet_debug u_debug (
    .clk(clk),
    .reset(reset),
    .halt_req(dbg_halt_req),
    .run_req(dbg_run_req),
    .step_req(dbg_step_req),
    .bp_enable(dbg_bp_enable),
    .bp_addr(dbg_bp_addr),
    .link(dbg_link)
  );

  assign dbg_link.pc = pc_reg;
  assign dbg_link.boundary = !busy;
  assign dbg_link.retire = retire_now;
  assign dbg_halted = dbg_link.halted;

  // a new instruction only starts when debug does not hold the core
  assign active = busy || !dbg_link.hold;
  // one byte per clock while bytes remain, no fetch afterwards
  assign need_fetch = ({2'h0, dec_bytes} > cnt_cur);
  assign fetch_ready = active && need_fetch;
  assign byte_taken = fetch_ready && fetch_valid;
  // an empty fetch bus stalls without counting a cycle
  assign advance = active && (!need_fetch || fetch_valid);
  assign fetch_addr = pc_reg;

  assign last_base = (cnt_cur == dec_cycles - 4'h1);
  assign cond_true = (opcode_cur == bcet_pkg::OP_JUMP_IF_ACC_ZERO) ?
                     acc_zero : branch_cond;
  assign take_now = dec_cond && cond_true;
  // not taken ends at the base count, taken one cycle later
  assign retire_now = advance &&
    ((last_base && !take_now && !(busy && take_reg)) ||
     (busy && take_reg && cnt_reg == dec_cycles));
  assign cnt_next = cnt_cur + 4'h1;

  assign rel_target = pc_reg + {{(ADDR_W-8){rel_reg[7]}}, rel_reg};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= bcet_pkg::ST_OPCODE;
    end else if (advance) begin
      if (retire_now) begin
        state_reg <= bcet_pkg::ST_OPCODE;
      end else begin
        state_reg <= bcet_pkg::ST_BUSY;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      op_reg <= 8'h00;
    end else if (advance && !busy) begin
      op_reg <= fetch_byte;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_reg <= '0;
    end else if (advance && !busy) begin
      start_reg <= pc_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 4'h0;
    end else if (advance) begin
      cnt_reg <= retire_now ? 4'h0 : cnt_next;
    end
  end

  // last fetched byte of a relative branch is its offset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rel_reg <= 8'h00;
    end else if (byte_taken && cnt_cur == {2'h0, dec_bytes} - 4'h1) begin
      rel_reg <= fetch_byte;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      take_reg <= 1'b0;
    end else if (advance) begin
      if (retire_now) begin
        take_reg <= 1'b0;
      end else if (last_base && take_now && !(busy && take_reg)) begin
        take_reg <= 1'b1;
      end
    end
  end

  // relative targets use the pc after the last byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc_reg <= '0;
    end else if (retire_now && (take_reg || dec_rel_jump)) begin
      pc_reg <= rel_target;
    end else if (retire_now && jump_valid) begin
      pc_reg <= jump_addr;
    end else if (byte_taken) begin
      pc_reg <= pc_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      retire_valid_reg <= 1'b0;
    end else begin
      retire_valid_reg <= retire_now;
    end
  end

  // identity of the encoding is kept; only timing is reported
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      retire_opcode_reg <= 8'h00;
    end else if (retire_now) begin
      retire_opcode_reg <= opcode_cur;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      retire_addr_reg <= '0;
    end else if (retire_now) begin
      retire_addr_reg <= start_cur;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      retire_bytes_reg <= 2'h0;
    end else if (retire_now) begin
      retire_bytes_reg <= dec_bytes;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      retire_cycles_reg <= 4'h0;
    end else if (retire_now) begin
      retire_cycles_reg <= cnt_next;
    end
  end

  // only conditional branches report taken; a short jump reports 0
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      retire_taken_reg <= 1'b0;
    end else if (retire_now) begin
      retire_taken_reg <= take_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      retire_undefined_reg <= 1'b0;
    end else if (retire_now) begin
      retire_undefined_reg <= dec_undefined;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cycle_count_reg <= '0;
    end else begin
      cycle_count_reg <= cycle_count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      instr_count_reg <= '0;
    end else if (retire_now) begin
      instr_count_reg <= instr_count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign retire_valid = retire_valid_reg;
  assign retire_opcode = retire_opcode_reg;
  assign retire_addr = retire_addr_reg;
  assign retire_bytes = retire_bytes_reg;
  assign retire_cycles = retire_cycles_reg;
  assign retire_taken = retire_taken_reg;
  assign retire_undefined = retire_undefined_reg;
  assign cycle_count = cycle_count_reg;
  assign instr_count = instr_count_reg;
endmodule

// File: testbench/bcet_core_sva.sv
/*
  Checker of retire timing, fetch order and debug hold at the ports.
  Assumes: bound to bcet_core; one clock; reset async, active high.
*/
`timescale 1ns/10ps
module bcet_core_sva #(
  parameter int ADDR_W = 16,
  parameter int CNT_W = 32
) (
  input wire logic clk,                 // system clock
  input wire logic reset,               // async, active high
  input wire logic fetch_valid,         // byte present
  input wire logic fetch_ready,         // byte wanted
  input wire logic [ADDR_W-1:0] fetch_addr, // wanted address
  input wire logic jump_valid,          // absolute redirect
  input wire logic dbg_halted,          // stopped at boundary
  input wire logic retire_valid,        // retire pulse
  input wire logic [7:0] retire_opcode, // retired opcode
  input wire logic [1:0] retire_bytes,  // its length
  input wire logic [3:0] retire_cycles, // its cycles
  input wire logic retire_taken,        // branch taken
  input wire logic retire_undefined,    // unused encoding
  input wire logic [CNT_W-1:0] cycle_count // clocks since reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_cycle_cap: assert property (
    retire_valid |-> retire_cycles != 4'h0 &&
    retire_cycles <= bcet_pkg::MAX_CYCLES)
    else $error("retire cycles out of range");
  chk_mul_time: assert property (
    retire_valid && retire_opcode == 8'ha4 |->
    retire_cycles == 4'h4 && retire_bytes == 2'h1)
    else $error("multiply timing wrong");
  chk_div_time: assert property (
    retire_valid && retire_opcode == 8'h84 |->
    retire_cycles == 4'h8 && retire_bytes == 2'h1)
    else $error("divide timing wrong");
  chk_zero_jump: assert property (
    retire_valid && retire_opcode == 8'h60 |-> retire_bytes == 2'h2 &&
    retire_cycles == (retire_taken ? 4'h3 : 4'h2))
    else $error("jump on zero timing wrong");
  // first edge after release still samples the reset value
  chk_clock_count: assert property (
    !$past(reset) |-> cycle_count == $past(cycle_count) + 1'b1)
    else $error("cycle count did not step by one");
  chk_arith_bank: assert property (
    retire_valid && retire_opcode[3] && (retire_opcode[7:4] == 4'h2 ||
    retire_opcode[7:4] == 4'h3 || retire_opcode[7:4] == 4'h9) |->
    retire_bytes == 2'h1 && retire_cycles == 4'h1)
    else $error("bank arithmetic timing wrong");
  chk_logic_bank: assert property (
    retire_valid && retire_opcode[3] && (retire_opcode[7:4] == 4'h4 ||
    retire_opcode[7:4] == 4'h5 || retire_opcode[7:4] == 4'h6) |->
    retire_bytes == 2'h1 && retire_cycles == 4'h1)
    else $error("bank logic timing wrong");
  chk_fetch_order: assert property (
    fetch_ready && fetch_valid && !jump_valid |=>
    fetch_addr == $past(fetch_addr) + 1'b1)
    else $error("fetch address did not advance");
  chk_halt_quiet: assert property (
    dbg_halted |-> !fetch_ready)
    else $error("byte wanted while halted");
  chk_halt_noretire: assert property (
    dbg_halted && $past(dbg_halted) |-> !retire_valid)
    else $error("retire while halted");
  chk_undef_flag: assert property (
    retire_valid && retire_opcode == bcet_pkg::OP_UNDEFINED |->
    retire_undefined && retire_bytes == 2'h1)
    else $error("unused encoding not flagged");
  cover property (retire_valid && retire_taken);
  cover property (retire_valid && retire_opcode == 8'h84);
  cover property (dbg_halted ##1 !dbg_halted);
endmodule

bind bcet_core bcet_core_sva #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_sva (
  .clk(clk), .reset(reset), .fetch_valid(fetch_valid),
  .fetch_ready(fetch_ready), .fetch_addr(fetch_addr),
  .jump_valid(jump_valid), .dbg_halted(dbg_halted),
  .retire_valid(retire_valid), .retire_opcode(retire_opcode),
  .retire_bytes(retire_bytes), .retire_cycles(retire_cycles),
  .retire_taken(retire_taken), .retire_undefined(retire_undefined),
  .cycle_count(cycle_count));

// File: testbench/bcet_prog_mem.sv
/*
  Program memory model on the far side of the fetch port.
  Assumes: loaded by the bench through mem; slow leaves one idle
  cycle after every byte taken.
*/
`timescale 1ns/10ps
module bcet_prog_mem (
  input wire logic clk,               // system clock
  input wire logic slow,              // stall mode
  input wire logic [15:0] fetch_addr, // wanted address
  input wire logic fetch_ready,       // core wants a byte
  output logic fetch_valid,           // byte present
  output logic [7:0] fetch_byte       // program byte
);
  logic [7:0] mem [0:255];
  logic took_reg = 1'b0;
  initial fetch_valid = 1'b1;
  always @(posedge clk) took_reg <= fetch_ready && fetch_valid;
  // valid held until the byte is taken
  always @(negedge clk) fetch_valid <= !(slow && took_reg);
  // no byte on offer shows the inverse, so a stale byte cannot pass
  assign fetch_byte = fetch_valid ? mem[fetch_addr[7:0]] :
    ~mem[fetch_addr[7:0]];
endmodule

// File: testbench/tb_top.sv
/*
  Self-checking bench for the instruction timing sequencer.
  Assumes: program memory model on the far side; 125 MHz clock.
*/
`timescale 1ns/10ps
module tb_top;
  typedef struct {
    logic [7:0] op;
    logic [15:0] addr;
    logic [3:0] cyc;
    logic [1:0] len;
    logic taken;
    logic [31:0] cc;
  } bcet_rec_type;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic slow = 1'b0;
  logic branch_cond = 1'b0;
  logic acc_zero = 1'b0;
  logic jump_valid = 1'b0;
  logic [15:0] jump_addr = 16'h0000;
  logic dbg_halt_req = 1'b0;
  logic dbg_run_req = 1'b0;
  logic dbg_step_req = 1'b0;
  logic dbg_bp_enable = 1'b0;
  logic [15:0] dbg_bp_addr = 16'h0000;
  logic fetch_valid, fetch_ready, dbg_halted, retire_valid;
  logic retire_taken, retire_undefined;
  logic [7:0] fetch_byte, retire_opcode;
  logic [15:0] fetch_addr, retire_addr;
  logic [1:0] retire_bytes;
  logic [3:0] retire_cycles;
  logic [31:0] cycle_count, instr_count;
  int error_cnt = 0;
  int num_checks = 0;
  bcet_rec_type recs[$];
  // entries: opcode, bytes, cycles
  logic [15:0] tbl[$] = '{16'h2811, 16'h2522, 16'h2612, 16'h2422,
    16'h3522, 16'h3911, 16'h9612, 16'h9422, 16'h0411, 16'h0811,
    16'h0522, 16'h0612, 16'h1411, 16'h1522, 16'h1612, 16'h1f11,
    16'ha311, 16'ha414, 16'h8418, 16'hd411, 16'h5811, 16'h5522,
    16'h5612, 16'h5422, 16'h5222, 16'h5333, 16'h4811, 16'h4222,
    16'h4333, 16'h6612, 16'h6422, 16'h6222, 16'h6333, 16'h6f11,
    16'ha511};

  always #4 clk = ~clk;

  bcet_core DUT (.clk(clk), .reset(reset), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte), .fetch_ready(fetch_ready),
    .fetch_addr(fetch_addr), .branch_cond(branch_cond),
    .acc_zero(acc_zero), .jump_valid(jump_valid), .jump_addr(jump_addr),
    .dbg_halt_req(dbg_halt_req), .dbg_run_req(dbg_run_req),
    .dbg_step_req(dbg_step_req), .dbg_bp_enable(dbg_bp_enable),
    .dbg_bp_addr(dbg_bp_addr), .dbg_halted(dbg_halted),
    .retire_valid(retire_valid), .retire_opcode(retire_opcode),
    .retire_addr(retire_addr), .retire_bytes(retire_bytes),
    .retire_cycles(retire_cycles), .retire_taken(retire_taken),
    .retire_undefined(retire_undefined), .cycle_count(cycle_count),
    .instr_count(instr_count));
  bcet_prog_mem PM (.clk(clk), .slow(slow), .fetch_addr(fetch_addr),
    .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte));

  always @(negedge clk) begin
    if (retire_valid === 1'b1) begin
      recs.push_back('{retire_opcode, retire_addr, retire_cycles,
        retire_bytes, retire_taken, cycle_count});
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen,
        exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic restart();
    reset = 1'b1;
    repeat (8) @(negedge clk);
    recs.delete();
    reset = 1'b0;
  endtask

  task automatic load(input logic [7:0] prog[$]);
    for (int i = 0; i < 256; i++) begin
      PM.mem[i] = (i < prog.size()) ? prog[i] : 8'h00;
    end
  endtask

  task automatic wait_recs(input int n);
    for (int i = 0; i < 2000 && recs.size() < n; i++) @(negedge clk);
    if (recs.size() < n) check(recs.size(), n);
  endtask

  task automatic pulse(input int w);
    dbg_halt_req = (w == 0);
    dbg_run_req = (w == 1);
    dbg_step_req = (w == 2);
    @(negedge clk);
    {dbg_halt_req, dbg_run_req, dbg_step_req} = 3'b000;
  endtask

  task automatic wait_halt();
    for (int i = 0; i < 50 && dbg_halted !== 1'b1; i++) @(negedge clk);
    check(dbg_halted, 1'b1);
    repeat (2) @(negedge clk);
  endtask

  task automatic t_timing(input logic slow_mode);
    logic [7:0] prog[$];
    logic [15:0] a;
    a = 16'h0000;
    foreach (tbl[i]) begin
      prog.push_back(tbl[i][15:8]);
      for (int k = 1; k < tbl[i][7:4]; k++) prog.push_back(8'h00);
    end
    prog.push_back(8'h80);
    prog.push_back(8'hfe);
    load(prog);
    slow = slow_mode;
    restart();
    wait_recs(tbl.size());
    foreach (tbl[i]) begin
      check(recs[i].op, tbl[i][15:8]);
      check(recs[i].addr, a);
      check(recs[i].len, tbl[i][5:4]);
      check(recs[i].cyc, tbl[i][3:0]);
      // stalls excluded, so spacing is compared with a fast memory only
      if (i > 0 && !slow_mode) begin
        check(recs[i].cc - recs[i-1].cc, tbl[i][3:0]);
      end
      a += tbl[i][7:4];
    end
    slow = 1'b0;
  endtask

  task automatic t_branch(input logic az, input logic bc,
      input logic [15:0] exp[$]);
    load('{8'h60, 8'h04, 8'h70, 8'h02, 8'h00, 8'h00, 8'h80, 8'hf8});
    acc_zero = az;
    branch_cond = bc;
    restart();
    wait_recs(exp.size());
    foreach (exp[i]) begin
      check(recs[i].addr, exp[i][15:8]);
      check(recs[i].cyc, exp[i][7:4]);
      check(recs[i].taken, exp[i][0]);
    end
  endtask

  task automatic t_redirect();
    load('{8'h00});
    jump_addr = 16'h0040;
    jump_valid = 1'b1;
    restart();
    wait_recs(3);
    check(recs[1].addr, 16'h0040);
    check(recs[2].addr, 16'h0040);
    jump_valid = 1'b0;
  endtask

  task automatic t_debug();
    int n;
    logic [15:0] bp;
    load('{8'h00});
    restart();
    repeat (5) @(negedge clk);
    pulse(0);
    wait_halt();
    n = recs.size();
    repeat (10) @(negedge clk);
    check(recs.size(), n);
    check(instr_count, n);
    pulse(2);
    wait_halt();
    check(recs.size(), n + 1);
    bp = fetch_addr + 16'h0005;
    dbg_bp_addr = bp;
    dbg_bp_enable = 1'b1;
    pulse(1);
    wait_halt();
    check(fetch_addr, bp);
    check(recs[recs.size()-1].addr, bp - 16'h0001);
    pulse(1);
    repeat (4) @(negedge clk);
    check(dbg_halted, 1'b0);
    dbg_bp_enable = 1'b0;
  endtask

  initial begin
    restart();
    t_timing(1'b0);
    t_timing(1'b1);
    t_branch(1'b0, 1'b0, '{16'h0020, 16'h0220, 16'h0410, 16'h0510,
      16'h0630, 16'h0020});
    t_branch(1'b1, 1'b1, '{16'h0031, 16'h0630, 16'h0031});
    t_branch(1'b0, 1'b1, '{16'h0020, 16'h0231, 16'h0630});
    t_redirect();
    t_debug();
    report_and_stop();
  end

  // whole run needs a few hundred cycles
  initial begin
    #(30000 * 8);
    error_cnt++;
    report_and_stop();
  end
endmodule
